/* core/can_ident_buffer.sv */
// Identifier buffer: APB registers, transmit arbitration serializer, receive store
// What this block does
// - Send 29-bit identifier, most significant bit first
// - Smaller identifier wins bus arbitration
// - Extended layout packs id, SRR, IDE, RTR
// - Standard layout packs 11-bit id, RTR, IDE
// - Received SRR stored exactly as sampled
// - IDE picks 11-bit or 29-bit transmission
// - Received IDE stored to show layout
// - Transmit RTR bit selects remote frame
// - Received RTR captured into receive buffer
//
// Local design decision: the APB slave port.
`include "can_ident_cfg.svh"
`default_nettype none
module can_ident_buffer (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_frame_start,
    input  wire logic        i_bit_tick,
    input  wire logic        i_bus_bit,
    input  wire logic        i_rx_valid,
    input  wire logic [28:0] i_rx_id,
    input  wire logic        i_rx_ide,
    input  wire logic        i_rx_srr,
    input  wire logic        i_rx_rtr,
    output logic             o_tx_bit,
    output logic             o_tx_active,
    output logic      [28:0] o_tx_id,
    output logic             o_tx_ide,
    output logic             o_tx_rtr
);
    // Serializer state
    can_ident_pkg::tx_state_t state_reg;
    can_ident_pkg::tx_state_t state_next;

    logic [31:0] tx_word;       // Transmit identifier bytes, assembled
    logic [31:0] rx_word_reg;   // Receive identifier bytes
    logic [31:0] rx_packed;     // Packed form of the incoming frame
    logic [31:0] shift_reg;     // Bits still to go, next one at the top
    logic [5:0]  bit_cnt_reg;   // Bits left after the current one
    logic        txe_reg;       // Transmit buffer empty
    logic        rxf_reg;       // Receive buffer full
    logic        arbl_reg;      // Arbitration lost, sticky
    logic        ovr_reg;       // Frame dropped while full, sticky
    logic [31:0] prdata_reg;    // Read data captured in setup
    logic [31:0] rd_mux;        // Selected read value

    // Field views shared with the codec
    ident_fields_if tx_if ();
    ident_fields_if rx_if ();

    // APB decode
    wire        setup_ph = i_psel & ~i_penable;
    wire        access   = i_psel & i_penable;
    wire [5:0]  idx      = i_paddr[7:2];
    wire        aligned  = (i_paddr[1:0] == 2'h0);
    wire        mapped   = aligned & (idx <= `IDX_CTRL);
    wire        wr_en    = access & i_pwrite & mapped;
    wire        ctrl_wr  = wr_en & (idx == `IDX_CTRL);
    // Unmapped or misaligned reads return zero rather than the last capture
    wire [31:0] rd_value = mapped ? rd_mux : 32'h0000_0000;

    // Zero wait states; unmapped or misaligned access answers with an error
    // Every access ends in its first access cycle, so no wait logic is needed
    assign o_pready  = 1'b1;
    assign o_pslverr = access & ~mapped;
    assign o_prdata  = prdata_reg;

    // Software commands in the control word
    wire tx_req  = ctrl_wr & i_pwdata[`CTRL_TXE_BIT] & txe_reg;
    wire rx_rel  = ctrl_wr & i_pwdata[`CTRL_RXF_BIT];
    wire arbl_clr = ctrl_wr & i_pwdata[`CTRL_ARBL_BIT];
    wire ovr_clr = ctrl_wr & i_pwdata[`CTRL_OVR_BIT];

    // Serializer events
    wire in_shift = (state_reg == can_ident_pkg::TX_SHIFT);
    wire tx_tick  = in_shift & i_bit_tick;
    // A recessive bit overwritten by a dominant one loses arbitration,
    // so the smaller identifier, dominant earlier, keeps the bus
    wire lost     = tx_tick & shift_reg[31] & ~i_bus_bit;
    wire last_bit = tx_tick & ~lost & (bit_cnt_reg == 6'd0);
    wire rx_store = i_rx_valid & ~rxf_reg;
    wire rx_drop  = i_rx_valid & rxf_reg;

    // Identifier format of the held transmit word sets the length
    wire       tx_ext  = tx_word[`WORD_IDE_BIT];
    wire [5:0] tx_last = tx_ext ? `EXT_LAST : `STD_LAST;

    // Per-byte transmit registers, writable only while the buffer is empty
    // Locking them while a send is pending keeps a retried field intact
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_tx_byte
            logic [7:0] byte_reg;
            wire        byte_wr = wr_en & txe_reg & (idx == 6'(b));
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    byte_reg <= 8'h00;
                end else if (byte_wr) begin
                    byte_reg <= i_pwdata[7:0];
                end
            end
            assign tx_word[31 - 8 * b -: 8] = byte_reg;
        end
    endgenerate

    // Frame fields for the codec
    // The engine shows them for one cycle only, together with i_rx_valid
    assign rx_if.id  = i_rx_id;
    assign rx_if.ide = i_rx_ide;
    assign rx_if.srr = i_rx_srr;
    assign rx_if.rtr = i_rx_rtr;

    // Packing and unpacking of the identifier bytes
    can_ident_codec u_codec (
        .i_tx_word (tx_word),
        .tx_fields (tx_if.src),
        .rx_fields (rx_if.snk),
        .o_rx_word (rx_packed)
    );

    // Parallel view of the transmit identifier for the protocol engine
    assign o_tx_id     = tx_if.id;
    assign o_tx_ide    = tx_if.ide;
    assign o_tx_rtr    = tx_if.rtr;
    assign o_tx_bit    = shift_reg[31];
    assign o_tx_active = in_shift;

    // Read selection; receive bytes and status are read-only
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (idx <= `IDX_IDENT_BYTE3) begin
            rd_mux[7:0] = tx_word[31 - 8 * idx[1:0] -: 8];
        end else if (idx <= `IDX_RX_BYTE3) begin
            rd_mux[7:0] = rx_word_reg[31 - 8 * idx[1:0] -: 8];
        end else if (idx == `IDX_CTRL) begin
            rd_mux[`CTRL_TXE_BIT]  = txe_reg;
            rd_mux[`CTRL_RXF_BIT]  = rxf_reg;
            rd_mux[`CTRL_ARBL_BIT] = arbl_reg;
            rd_mux[`CTRL_OVR_BIT]  = ovr_reg;
        end
    end

    // Read data is sampled in setup so it stands through the access phase
    // Capturing a cycle early keeps o_prdata off the address decode path
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_ph & ~i_pwrite) begin
            prdata_reg <= rd_value;
        end
    end

    // Next serializer state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            can_ident_pkg::TX_IDLE: begin
                if (tx_req) begin
                    state_next = can_ident_pkg::TX_READY;
                end
            end
            can_ident_pkg::TX_READY: begin
                // Waits for the engine to open a frame
                if (i_frame_start) begin
                    state_next = can_ident_pkg::TX_SHIFT;
                end
            end
            can_ident_pkg::TX_SHIFT: begin
                // A loss retries at the next frame start
                if (lost) begin
                    state_next = can_ident_pkg::TX_READY;
                end else if (last_bit) begin
                    state_next = can_ident_pkg::TX_IDLE;
                end
            end
            default: begin
                // The unused code recovers to idle
                state_next = can_ident_pkg::TX_IDLE;
            end
        endcase
    end

    // State register
    // Reset drops an armed send; software must request it again
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= can_ident_pkg::TX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Shift register: loaded at frame start, moves one bit per tick
    // Ones fill in from the bottom, so the line is recessive once an extended frame is done; a standard frame leaves word bit 18 at the top
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            shift_reg   <= `ID_WORD_RESET;
            bit_cnt_reg <= 6'd0;
        end else if (state_reg == can_ident_pkg::TX_READY && i_frame_start) begin
            shift_reg   <= tx_word;
            bit_cnt_reg <= tx_last;
        end else if (tx_tick & ~lost) begin
            shift_reg   <= {shift_reg[30:0], 1'b1};
            bit_cnt_reg <= bit_cnt_reg - 6'd1;
        end
    end

    // Empty flag: cleared by the send request, set when the last bit goes
    // A loss leaves it clear, since the frame is still owed to the bus
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            txe_reg <= 1'b1;
        end else if (last_bit) begin
            txe_reg <= 1'b1;
        end else if (tx_req) begin
            txe_reg <= 1'b0;
        end
    end

    // Sticky error flags; a new event wins over a clear in the same cycle
    // Software that clears a flag being set again finds it still set
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            arbl_reg <= 1'b0;
            ovr_reg  <= 1'b0;
        end else begin
            arbl_reg <= lost | (arbl_reg & ~arbl_clr);
            ovr_reg  <= rx_drop | (ovr_reg & ~ovr_clr);
        end
    end

    // Receive store; a full buffer keeps the older frame untouched
    // Unused standard bits are stored as zero; software must not use them
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_word_reg <= `ID_WORD_RESET;
        end else if (rx_store) begin
            rx_word_reg <= rx_packed;
        end
    end

    // Full flag; a release wins over a frame arriving in the same cycle, which is dropped
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rxf_reg <= 1'b0;
        end else begin
            rxf_reg <= rx_store | (rxf_reg & ~rx_rel);
        end
    end

    // Checks of the serializer and the receive packing
    a_shift_order: assert property (@(posedge i_clk) disable iff (i_srst)
        tx_tick && !lost && bit_cnt_reg != 6'd0 |=> o_tx_bit == $past(shift_reg[30]))
        else $error("identifier bit order broken");

    a_arb_priority: assert property (@(posedge i_clk) disable iff (i_srst)
        lost |=> state_reg == can_ident_pkg::TX_READY && arbl_reg && !txe_reg)
        else $error("arbitration loss not handled");

    a_ext_pack: assert property (@(posedge i_clk) disable iff (i_srst)
        rx_store && i_rx_ide |=> rx_word_reg[31:21] == $past(i_rx_id[28:18])
            && rx_word_reg[18:1] == $past(i_rx_id[17:0]))
        else $error("extended identifier packed wrongly");

    a_std_pack: assert property (@(posedge i_clk) disable iff (i_srst)
        rx_store && !i_rx_ide |=> rx_word_reg[31:21] == $past(i_rx_id[10:0]))
        else $error("standard identifier packed wrongly");

    a_srr_stored: assert property (@(posedge i_clk) disable iff (i_srst)
        rx_store && i_rx_ide |=> rx_word_reg[`WORD_SRR_BIT] == $past(i_rx_srr))
        else $error("received SRR not kept");

    a_len_select: assert property (@(posedge i_clk) disable iff (i_srst)
        state_reg == can_ident_pkg::TX_READY && i_frame_start
        |=> bit_cnt_reg == ($past(tx_ext) ? 6'd31 : 6'd12))
        else $error("frame length does not follow IDE");

    a_rx_ide: assert property (@(posedge i_clk) disable iff (i_srst)
        rx_store |=> rx_word_reg[`WORD_IDE_BIT] == $past(i_rx_ide) && rxf_reg)
        else $error("received IDE not kept");

    a_tx_rtr: assert property (@(posedge i_clk) disable iff (i_srst)
        state_reg == can_ident_pkg::TX_READY && i_frame_start && !tx_ext
        |=> shift_reg[`WORD_RTR_STD_BIT] == $past(o_tx_rtr))
        else $error("sent RTR differs from buffer");

    a_rx_rtr: assert property (@(posedge i_clk) disable iff (i_srst)
        rx_store && !i_rx_ide |=> rx_word_reg[`WORD_RTR_STD_BIT] == $past(i_rx_rtr))
        else $error("received RTR not kept");

    a_rx_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        rx_drop |=> $stable(rx_word_reg) && ovr_reg)
        else $error("full receive buffer overwritten");

    // Checks of the extended fields, the frame end and the refusals
    a_ext_rtr_sent: assert property (@(posedge i_clk) disable iff (i_srst)
        state_reg == can_ident_pkg::TX_READY && i_frame_start && tx_ext
        |=> shift_reg[`WORD_RTR_EXT_BIT] == $past(o_tx_rtr))
        else $error("sent extended RTR differs from buffer");

    a_ext_rx_rtr: assert property (@(posedge i_clk) disable iff (i_srst)
        rx_store && i_rx_ide |=> rx_word_reg[`WORD_RTR_EXT_BIT] == $past(i_rx_rtr))
        else $error("received extended RTR not kept");

    a_first_bit: assert property (@(posedge i_clk) disable iff (i_srst)
        state_reg == can_ident_pkg::TX_READY && i_frame_start
        |=> o_tx_active && o_tx_bit == $past(tx_word[31]))
        else $error("first identifier bit not presented");

    a_loss_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
        lost |=> !o_tx_active && $stable(shift_reg))
        else $error("serializer kept driving after a loss");

    a_done_empty: assert property (@(posedge i_clk) disable iff (i_srst)
        last_bit |=> txe_reg && !o_tx_active)
        else $error("finished frame left the buffer busy");

    a_tx_locked: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_en && !txe_reg && idx <= `IDX_IDENT_BYTE3 |=> $stable(tx_word))
        else $error("pending transmit bytes overwritten");

    a_rd_zero: assert property (@(posedge i_clk) disable iff (i_srst)
        setup_ph && !i_pwrite && !mapped |=> o_prdata == 32'h0000_0000)
        else $error("unmapped read returned stale data");

    // Main scenarios
    c_ext_sent: cover property (@(posedge i_clk) disable iff (i_srst)
        last_bit && tx_ext);
    c_std_sent: cover property (@(posedge i_clk) disable iff (i_srst)
        last_bit && !tx_ext);
    c_arb_lost: cover property (@(posedge i_clk) disable iff (i_srst) lost);
    c_rx_ext: cover property (@(posedge i_clk) disable iff (i_srst)
        rx_store && i_rx_ide);
    c_rx_std: cover property (@(posedge i_clk) disable iff (i_srst)
        rx_store && !i_rx_ide);
endmodule
`default_nettype wire

/* core/can_ident_codec.sv */
// Packs and unpacks identifier fields to and from the four-byte layout
`include "can_ident_cfg.svh"
`default_nettype none
module can_ident_codec (
    input  wire logic [31:0] i_tx_word,
    ident_fields_if.src      tx_fields,
    ident_fields_if.snk      rx_fields,
    output logic      [31:0] o_rx_word
);
    // Format of the stored transmit word
    wire tx_ext = i_tx_word[`WORD_IDE_BIT];

    // Unpack: extended takes all 29 bits, standard only byte 0 and top of byte 1
    assign tx_fields.ide = tx_ext;
    assign tx_fields.id  = tx_ext ? {i_tx_word[31:21], i_tx_word[18:1]}
                                  : {18'h0_0000, i_tx_word[31:21]};
    assign tx_fields.srr = tx_ext ? i_tx_word[`WORD_SRR_BIT] : 1'b0;
    assign tx_fields.rtr = tx_ext ? i_tx_word[`WORD_RTR_EXT_BIT]
                                  : i_tx_word[`WORD_RTR_STD_BIT];

    // Pack extended: id[28:18], SRR as sampled, IDE, id[17:0], RTR
    wire [31:0] ext_word = {rx_fields.id[28:18], rx_fields.srr, 1'b1,
                            rx_fields.id[17:0], rx_fields.rtr};
    // Pack standard: id[10:0], RTR, IDE; unused bits left at zero
    wire [31:0] std_word = {rx_fields.id[10:0], rx_fields.rtr, 1'b0,
                            19'h0_0000};

    // Layout chosen by the received IDE bit
    assign o_rx_word = rx_fields.ide ? ext_word : std_word;
endmodule
`default_nettype wire

/* include/can_ident_cfg.svh */
// Offsets, field positions, reset values and counts of the identifier buffer
`ifndef CAN_IDENT_CFG_SVH
`define CAN_IDENT_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_IDENT_BYTE0 6'h00
`define IDX_IDENT_BYTE1 6'h01
`define IDX_IDENT_BYTE2 6'h02
`define IDX_IDENT_BYTE3 6'h03
`define IDX_RX_BYTE0    6'h04
`define IDX_RX_BYTE3    6'h07
`define IDX_CTRL        6'h08

// Control and status bit positions
`define CTRL_TXE_BIT  0
`define CTRL_RXF_BIT  1
`define CTRL_ARBL_BIT 2
`define CTRL_OVR_BIT  3

// Positions in the packed 32-bit identifier word (byte 0 in bits 31:24)
`define WORD_SRR_BIT     20
`define WORD_IDE_BIT     19
`define WORD_RTR_STD_BIT 20
`define WORD_RTR_EXT_BIT 0

// Serial lengths of the arbitration fields, minus one
`define STD_LAST 6'd12
`define EXT_LAST 6'd31

// Reset values
`define ID_WORD_RESET 32'h0000_0000
`define STATUS_RESET  8'h00

`endif

/* include/can_ident_pkg.sv */
// Types shared by the identifier buffer modules
`default_nettype none
package can_ident_pkg;
    // Transmit serializer states
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_READY,
        TX_SHIFT
    } tx_state_t;
endpackage
`default_nettype wire

/* include/ident_fields_if.sv */
// Unpacked identifier fields passed between the buffer and its codec
`default_nettype none
interface ident_fields_if;
    logic [28:0] id;   // Identifier, 29 or 11 significant bits
    logic        ide;  // Extended format
    logic        srr;  // Substitute remote request
    logic        rtr;  // Remote frame
    modport src (output id, output ide, output srr, output rtr);
    modport snk (input id, input ide, input srr, input rtr);
endinterface
`default_nettype wire

/* test/can_engine_model.sv */
// Protocol engine stand-in: frame timing, wired bus level and received identifiers
`default_nettype none
module can_engine_model (
    input  wire logic        i_clk,
    input  wire logic        i_tx_bit,
    input  wire logic        i_tx_active,
    output logic             o_frame_start,
    output logic             o_bit_tick,
    output logic             o_bus_bit,
    output logic             o_rx_valid,
    output logic      [28:0] o_rx_id,
    output logic             o_rx_ide,
    output logic             o_rx_srr,
    output logic             o_rx_rtr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus is recessive, no strobes
    initial begin
        o_frame_start = 1'b0;
        o_bit_tick    = 1'b0;
        o_bus_bit     = 1'b1;
        o_rx_valid    = 1'b0;
        {o_rx_id, o_rx_ide, o_rx_srr, o_rx_rtr} = '0;
    end

    // One arbitration field; the bus is the wired AND of both nodes, so a
    // dominant rival bit beats our recessive one and a silent node adds nothing
    task automatic frame(input logic [31:0] rival, input int n, output logic [31:0] seen);
        seen = 32'h0;
        o_frame_start <= 1'b1;
        @(posedge i_clk);
        o_frame_start <= 1'b0;
        @(posedge i_clk);
        for (int k = 31; k > 31 - n; k--) begin
            // A bit shown while the serializer is not active counts as unknown
            seen[k] = i_tx_active ? i_tx_bit : 1'bx;
            o_bus_bit  <= (i_tx_bit | ~i_tx_active) & rival[k];
            o_bit_tick <= 1'b1;
            @(posedge i_clk);
            o_bit_tick <= 1'b0;
            @(posedge i_clk);
        end
        o_bus_bit <= 1'b1;
    endtask

    // One received identifier; afterwards the field lines show the inverse,
    // so a design that samples late never sees the old value by luck
    task automatic rx(input logic [28:0] id, input logic ide, srr, rtr);
        {o_rx_id, o_rx_ide, o_rx_srr, o_rx_rtr} <= {id, ide, srr, rtr};
        o_rx_valid <= 1'b1;
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        {o_rx_id, o_rx_ide, o_rx_srr, o_rx_rtr} <= ~{id, ide, srr, rtr};
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

/* test/tb_can_ident_buffer.sv */
// Bench for the identifier buffer: APB driver, read scoreboard, frame checks
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_can_ident_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, srst = 1'b1;             // Clock and reset
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;                       // Byte address
    logic [31:0] pwdata = 32'h0, prdata;              // Bus data
    logic        pready, pslverr;                     // Slave answer
    logic        fs, tick, bus, rxv, rx_ide, rx_srr, rx_rtr;
    logic [28:0] rx_id, tx_id;                        // Identifier fields
    logic        tx_bit, tx_act, tx_ide, tx_rtr;      // Transmit side
    logic [32:0] exp_q[$];                            // Notes: {error, read data}
    int          failures = 0, checked = 0;

    always #20 clk = ~clk;

    can_ident_buffer dut_u (.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_frame_start(fs), .i_bit_tick(tick),
        .i_bus_bit(bus), .i_rx_valid(rxv), .i_rx_id(rx_id), .i_rx_ide(rx_ide),
        .i_rx_srr(rx_srr), .i_rx_rtr(rx_rtr), .o_tx_bit(tx_bit), .o_tx_active(tx_act),
        .o_tx_id(tx_id), .o_tx_ide(tx_ide), .o_tx_rtr(tx_rtr));

    can_engine_model eng_u (.i_clk(clk), .i_tx_bit(tx_bit), .i_tx_active(tx_act),
        .o_frame_start(fs), .o_bit_tick(tick), .o_bus_bit(bus), .o_rx_valid(rxv),
        .o_rx_id(rx_id), .o_rx_ide(rx_ide), .o_rx_srr(rx_srr), .o_rx_rtr(rx_rtr));

    // Scoreboard: every finished read is matched against the oldest note
    always @(posedge clk) begin
        logic [32:0] note;
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            `CHK({pslverr, prdata}, note)
        end
    end

    // Verdict, reached from the main sequence or from a spent wait
    task automatic wrap_up();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        if (!wr)
            exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            failures++;
            wrap_up();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, {25'h0, e});
    endtask

    // Load a word, check the decode, request a send and run one frame
    task automatic xmit(input logic [31:0] w, input int n, input logic [31:0] rival,
                        input logic [7:0] ctl);
        logic [31:0] seen;
        for (int i = 0; i < 4; i++) wr(8'(4 * i), {24'h0, w[31 - 8 * i -: 8]});
        for (int i = 0; i < 4; i++) rd(8'(4 * i), w[31 - 8 * i -: 8]);
        `CHK({tx_ide, tx_rtr}, {w[19], (n == 32) ? w[0] : w[20]})
        `CHK(tx_id, (n == 32) ? {w[31:21], w[18:1]} : {18'h0, w[31:21]})
        wr(8'h20, 32'h1);
        // Pending buffer must not change under the engine
        wr(8'h00, {24'h0, ~w[31:24]});
        rd(8'h00, w[31:24]);
        eng_u.frame(rival, n, seen);
        if (rival == 32'hFFFF_FFFF)
            `CHK(seen >> (32 - n), w >> (32 - n))
        rd(8'h20, ctl);
        `CHK(tx_act, 1'b0)
    endtask

    initial begin
        logic [28:0] id;
        logic        rtr, srr;
        logic [31:0] w, seen;
        void'($urandom(37));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // Reset state, then an unmapped and a misaligned place
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 8'h00);
        rd(8'h20, 8'h01);
        apb(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 8'h02, 32'h0, {1'b1, 32'h0});
        // Standard then extended transmission of random identifiers
        for (int f = 0; f < 2; f++) begin
            id  = 29'($urandom());
            rtr = 1'($urandom());
            w   = f ? {id[28:18], 2'b11, id[17:0], rtr} : {id[10:0], rtr, 20'h0};
            xmit(w, f ? 32 : 13, 32'hFFFF_FFFF, 8'h01);
        end
        // A rival with a smaller identifier wins; ours is retried intact
        id = 29'($urandom()) | 29'h0010_0000;
        w  = {id[28:18], 2'b11, id[17:0], 1'b0};
        xmit(w, 32, w & 32'hFF7F_FFFF, 8'h04);
        eng_u.frame(32'hFFFF_FFFF, 32, seen);
        `CHK(seen, w)
        rd(8'h20, 8'h05);
        wr(8'h20, 32'h4);
        rd(8'h20, 8'h01);
        // Receive both layouts; a second frame while full is dropped
        for (int f = 0; f < 2; f++) begin
            id  = 29'($urandom());
            rtr = 1'($urandom());
            srr = 1'($urandom());
            w   = f ? {id[28:18], srr, 1'b1, id[17:0], rtr} : {id[10:0], rtr, 20'h0};
            eng_u.rx(f ? id : {18'h0, id[10:0]}, 1'(f), srr, rtr);
            eng_u.rx(~id, 1'b1, 1'b1, ~rtr);
            rd(8'h20, 8'h0B);
            for (int i = 0; i < 4; i++) rd(8'h10 + 8'(4 * i), w[31 - 8 * i -: 8]);
            wr(8'h10, 32'hFF);
            rd(8'h10, w[31:24]);
            wr(8'h20, 32'hA);
            rd(8'h20, 8'h01);
        end
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
